// ==== src/cls_defines.vh ====
// Shared constants for the CCD line-table sequencer.
// Operation
// [R01] Line tables live in register group nine; defaults load automatically after reset.
// [R02] Each entry: duration count, horizontal gate bit, six vertical bits driven for count.
// [R03] A zero-count entry ends the table and hands control back to frame logic.
// [R04] Output f is fast dump, d first phase, c second, a strobe, b enable.
// [R05] Line-transfer defaults: counts 1,1,30,1,30,1,0; c in 1-3, d in 2, gate in 5.
// [R06] Line transfer clocks vertically first, then runs horizontal clocks for readout.
// [R07] Overlap between first and second vertical phases is adjustable by software.
// [R08] Photodiode-transfer defaults: 1,500,1,240,1,400,1310,0; c 1-5, d 3, a 2-4.
// [R09] Integration default: one count-1 entry with gate set, then terminator.
// [R10] Binning line-transfer defaults: two phase pulse pairs, gate only in entry 8.
// [R11] Line-flush defaults: 1,1,198,1,199,0; fast dump high through entries 0-4.
// [R12] Line flush never sets the horizontal gate after its vertical transfer.
// [R13] Hold default: one count-1 entry, everything low, then terminator.
// [R14] Three more default tables, six to eight, serve the photodiode flush sequence.
// [R15] Flush-start defaults: 1,25,1,25,0; c 1-3, a 2-3, d 3.
// [R16] Flush-end defaults: 10,10,25,2,0; d 0, c 0-2, a 0-1.
// [R17] Between-pulse flush defaults: 20,200,20,10,1,0; c 0,2-4, d 3-4, a 4.
// [R18] Hold table lasts one pixel time and repeats while awaiting the trigger.
// [R19] Integration table repeats until the vertical-drive trigger is asserted.
// [R20] Counts are pixel clocks; each pattern holds exactly that many clocks.
`ifndef CLS_DEFINES_VH
`define CLS_DEFINES_VH

// Entry layout.
`define CLS_ENTRY_W 19
`define CLS_CNT_MSB 11
`define CLS_HGATE_BIT 12
`define CLS_VA_BIT 13
`define CLS_VB_BIT 14
`define CLS_VC_BIT 15
`define CLS_VD_BIT 16
`define CLS_VE_BIT 17
`define CLS_VF_BIT 18

// Storage geometry.
`define CLS_NUM_TABLES 9
`define CLS_NUM_ENTRIES 10
`define CLS_NUM_WORDS 90

// Register map (byte addresses).
`define CLS_ADDR_TABLE_LAST 8'h8f
`define CLS_ADDR_REPEAT 8'ha0
`define CLS_ADDR_OVERLAP 8'ha4
`define CLS_ADDR_STATUS 8'ha8

// Reset values.
`define CLS_REPEAT_RST 9'h024
`define CLS_OVERLAP_RST 8'h00

`endif

// ==== src/cls_default_rom.v ====
// Default line-table contents, indexed by table and entry.
`timescale 1ns/100ps
`default_nettype none
`include "cls_defines.vh"

module cls_default_rom (
  // Lookup
  input wire [3:0] tableIdx,
  input wire [3:0] entryIdx,
  output reg [`CLS_ENTRY_W-1:0] word
);

  // Vertical bits are given as f,e,d,c,b,a.
  function [`CLS_ENTRY_W-1:0] mk;
    input [11:0] cnt;
    input hg;
    input [5:0] v;
    begin
      mk = {v, hg, cnt};
    end
  endfunction

  // Entries not listed are terminators: count zero, all outputs low.
  always @* begin
    case ({tableIdx, entryIdx})
      8'h00: word = mk(12'h001, 1'b0, 6'h00); // R05
      8'h01: word = mk(12'h001, 1'b0, 6'h04);
      8'h02: word = mk(12'h01e, 1'b0, 6'h0c);
      8'h03: word = mk(12'h001, 1'b0, 6'h04);
      8'h04: word = mk(12'h01e, 1'b0, 6'h00);
      8'h05: word = mk(12'h001, 1'b1, 6'h00); // R06
      8'h10: word = mk(12'h001, 1'b0, 6'h00); // R08
      8'h11: word = mk(12'h1f4, 1'b0, 6'h04);
      8'h12: word = mk(12'h001, 1'b0, 6'h05);
      8'h13: word = mk(12'h0f0, 1'b0, 6'h0d);
      8'h14: word = mk(12'h001, 1'b0, 6'h05);
      8'h15: word = mk(12'h190, 1'b0, 6'h04);
      8'h16: word = mk(12'h51e, 1'b0, 6'h00);
      8'h20: word = mk(12'h001, 1'b1, 6'h00); // R09
      8'h30: word = mk(12'h001, 1'b0, 6'h00); // R10
      8'h31: word = mk(12'h001, 1'b0, 6'h04);
      8'h32: word = mk(12'h01e, 1'b0, 6'h0c);
      8'h33: word = mk(12'h001, 1'b0, 6'h04);
      8'h34: word = mk(12'h01e, 1'b0, 6'h00);
      8'h35: word = mk(12'h001, 1'b0, 6'h04);
      8'h36: word = mk(12'h01e, 1'b0, 6'h0c);
      8'h37: word = mk(12'h001, 1'b0, 6'h04);
      8'h38: word = mk(12'h01e, 1'b1, 6'h00);
      8'h40: word = mk(12'h001, 1'b0, 6'h20); // R11
      8'h41: word = mk(12'h001, 1'b0, 6'h24);
      8'h42: word = mk(12'h0c6, 1'b0, 6'h2c);
      8'h43: word = mk(12'h001, 1'b0, 6'h24);
      8'h44: word = mk(12'h0c7, 1'b0, 6'h20); // R12
      8'h50: word = mk(12'h001, 1'b0, 6'h00); // R13
      8'h60: word = mk(12'h001, 1'b0, 6'h00); // R14 R15
      8'h61: word = mk(12'h019, 1'b0, 6'h04);
      8'h62: word = mk(12'h001, 1'b0, 6'h05);
      8'h63: word = mk(12'h019, 1'b0, 6'h0d);
      8'h70: word = mk(12'h00a, 1'b0, 6'h0d); // R16
      8'h71: word = mk(12'h00a, 1'b0, 6'h05);
      8'h72: word = mk(12'h019, 1'b0, 6'h04);
      8'h73: word = mk(12'h002, 1'b0, 6'h00);
      8'h80: word = mk(12'h014, 1'b0, 6'h04); // R17
      8'h81: word = mk(12'h0c8, 1'b0, 6'h00);
      8'h82: word = mk(12'h014, 1'b0, 6'h04);
      8'h83: word = mk(12'h00a, 1'b0, 6'h0c);
      8'h84: word = mk(12'h001, 1'b0, 6'h0d);
      default: word = {`CLS_ENTRY_W{1'b0}};
    endcase
  end

endmodule
`default_nettype wire

// ==== src/cls_phase_stretch.v ====
// Holds a vertical phase high for a programmable number of extra clocks.
`timescale 1ns/100ps
`default_nettype none

module cls_phase_stretch (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Phase
  input wire phaseIn,
  input wire [3:0] extend,
  output wire phaseOut
);

  reg [3:0] holdCnt_r;

  // Reloads while the phase is high so the tail starts at the falling edge.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_r <= 4'h0;
    end else if (phaseIn) begin
      holdCnt_r <= extend;
    end else if (holdCnt_r != 4'h0) begin
      holdCnt_r <= holdCnt_r - 4'h1;
    end
  end

  assign phaseOut = phaseIn | (holdCnt_r != 4'h0);

endmodule
`default_nettype wire

// ==== src/cls_line_sequencer.v ====
// Line-table storage, default loader, register port and entry sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "cls_defines.vh"

module cls_line_sequencer (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  // Frame sequencing side
  input wire lineStart,
  input wire [3:0] lineTable,
  input wire verticalDriveTrigger,
  output reg lineDone,
  output wire seqBusy,
  // CCD clock drivers
  output reg verticalOutA,
  output reg verticalOutB,
  output reg verticalOutC,
  output reg verticalOutD,
  output reg verticalOutE,
  output reg verticalOutF,
  output wire fastDumpGateOut,
  output wire thirdLevelStrobe,
  output wire verticalDriverEnable,
  output reg horizontalGate
);

  localparam [2:0] ST_LOAD = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [`CLS_ENTRY_W-1:0] lineMem [0:`CLS_NUM_WORDS-1];
  reg [2:0] state_r;
  reg [3:0] loadTab_r;
  reg [3:0] loadEnt_r;
  reg [3:0] curTab_r;
  reg [3:0] curEnt_r;
  reg [11:0] cnt_r;
  reg [`CLS_ENTRY_W-1:0] pat_r;
  reg trigSeen_r;
  reg [8:0] repeatMask_r;
  reg [7:0] overlap_r;
  wire [`CLS_ENTRY_W-1:0] romWord;
  wire stretchC;
  wire stretchD;

  ////////////////////////////////////////////////////////////////////////////
  // Address helpers.

  function [6:0] wordIdx;
    input [3:0] t;
    input [3:0] e;
    begin
      wordIdx = {t, 3'b000} + {2'b00, t, 1'b0} + {3'b000, e};
    end
  endfunction

  wire busInTable = (regAddr <= `CLS_ADDR_TABLE_LAST) &&
    (regAddr[3:0] < 4'ha);
  wire [6:0] busIdx = wordIdx(regAddr[7:4], regAddr[3:0]);
  wire [6:0] loadIdx = wordIdx(loadTab_r, loadEnt_r);
  wire [3:0] nextEnt = curEnt_r + 4'h1;
  wire lastSlot = (nextEnt == 4'ha);
  wire [`CLS_ENTRY_W-1:0] nextWord = lastSlot ? {`CLS_ENTRY_W{1'b0}} :
    lineMem[wordIdx(curTab_r, nextEnt)];
  wire [`CLS_ENTRY_W-1:0] firstWord = lineMem[wordIdx(lineTable, 4'h0)];
  wire [`CLS_ENTRY_W-1:0] restartWord = lineMem[wordIdx(curTab_r, 4'h0)];
  wire tableOk = (lineTable < 4'h9);
  wire keepLooping = repeatMask_r[curTab_r] && !trigSeen_r &&
    !verticalDriveTrigger;

  cls_default_rom uRom (
    .tableIdx(loadTab_r),
    .entryIdx(loadEnt_r),
    .word(romWord)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Storage: defaults walked in after reset, software may overwrite later.

  integer i;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < `CLS_NUM_WORDS; i = i + 1) begin
        lineMem[i] <= {`CLS_ENTRY_W{1'b0}};
      end
    end else if (state_r == ST_LOAD) begin
      lineMem[loadIdx] <= romWord; // R01
    end else if (regWr && busInTable) begin
      lineMem[busIdx] <= regWdata[`CLS_ENTRY_W-1:0]; // R01
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      repeatMask_r <= `CLS_REPEAT_RST;
      overlap_r <= `CLS_OVERLAP_RST;
    end else if (regWr) begin
      if (regAddr == `CLS_ADDR_REPEAT) begin
        repeatMask_r <= regWdata[8:0];
      end
      if (regAddr == `CLS_ADDR_OVERLAP) begin
        overlap_r <= regWdata[7:0]; // R07
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      if (busInTable) begin
        regRdata <= {13'h0000, lineMem[busIdx]};
      end else if (regAddr == `CLS_ADDR_REPEAT) begin
        regRdata <= {23'h00_0000, repeatMask_r};
      end else if (regAddr == `CLS_ADDR_OVERLAP) begin
        regRdata <= {24'h00_0000, overlap_r};
      end else if (regAddr == `CLS_ADDR_STATUS) begin
        regRdata <= {20'h0_0000, curEnt_r, curTab_r, 1'b0, trigSeen_r,
          state_r == ST_LOAD, state_r == ST_RUN};
      end else begin
        regRdata <= 32'h0000_0000;
      end
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_LOAD;
      loadTab_r <= 4'h0;
      loadEnt_r <= 4'h0;
      curTab_r <= 4'h0;
      curEnt_r <= 4'h0;
      cnt_r <= 12'h000;
      pat_r <= {`CLS_ENTRY_W{1'b0}};
      trigSeen_r <= 1'b0;
      lineDone <= 1'b0;
    end else begin
      lineDone <= 1'b0;
      if (state_r == ST_RUN && verticalDriveTrigger) begin
        trigSeen_r <= 1'b1; // R19
      end
      case (state_r)
        ST_LOAD: begin
          if (loadEnt_r == 4'h9) begin
            loadEnt_r <= 4'h0;
            if (loadTab_r == 4'h8) begin
              state_r <= ST_IDLE;
            end else begin
              loadTab_r <= loadTab_r + 4'h1;
            end
          end else begin
            loadEnt_r <= loadEnt_r + 4'h1;
          end
        end
        ST_IDLE: begin
          if (lineStart && tableOk) begin
            curTab_r <= lineTable;
            curEnt_r <= 4'h0;
            trigSeen_r <= 1'b0;
            if (firstWord[`CLS_CNT_MSB:0] == 12'h000) begin
              lineDone <= 1'b1; // R03
            end else begin
              cnt_r <= firstWord[`CLS_CNT_MSB:0];
              pat_r <= firstWord; // R02
              state_r <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (cnt_r != 12'h001) begin
            cnt_r <= cnt_r - 12'h001; // R20
          end else if (nextWord[`CLS_CNT_MSB:0] != 12'h000) begin
            curEnt_r <= nextEnt; // R06
            cnt_r <= nextWord[`CLS_CNT_MSB:0]; // R20
            pat_r <= nextWord; // R02
          end else if (keepLooping) begin
            curEnt_r <= 4'h0; // R18 R19
            cnt_r <= restartWord[`CLS_CNT_MSB:0];
            pat_r <= restartWord;
          end else begin
            // A zero-count first entry never reaches here; ST_IDLE ends it at the start.
            pat_r <= {`CLS_ENTRY_W{1'b0}};
            lineDone <= 1'b1; // R03
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign seqBusy = (state_r != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: every pin passes one register so all edges line up.

  cls_phase_stretch uStretchC (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .phaseIn(pat_r[`CLS_VC_BIT]),
    .extend(overlap_r[3:0]),
    .phaseOut(stretchC)
  );

  cls_phase_stretch uStretchD (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .phaseIn(pat_r[`CLS_VD_BIT]),
    .extend(overlap_r[7:4]),
    .phaseOut(stretchD)
  );

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      verticalOutA <= 1'b0;
      verticalOutB <= 1'b0;
      verticalOutC <= 1'b0;
      verticalOutD <= 1'b0;
      verticalOutE <= 1'b0;
      verticalOutF <= 1'b0;
      horizontalGate <= 1'b0;
    end else begin
      verticalOutA <= pat_r[`CLS_VA_BIT];
      verticalOutB <= pat_r[`CLS_VB_BIT];
      verticalOutC <= stretchC; // R07
      verticalOutD <= stretchD; // R07
      verticalOutE <= pat_r[`CLS_VE_BIT];
      verticalOutF <= pat_r[`CLS_VF_BIT];
      horizontalGate <= pat_r[`CLS_HGATE_BIT];
    end
  end

  assign fastDumpGateOut = verticalOutF; // R04
  assign thirdLevelStrobe = verticalOutA; // R04
  assign verticalDriverEnable = verticalOutB; // R04

endmodule
`default_nettype wire

// ==== testbench/cls_line_sequencer_assertions.sv ====
// Port-level checks for the line-table sequencer.
`timescale 1ns/100ps
`default_nettype none
module cls_line_sequencer_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register and line ports
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic lineStart,
  input wire logic [3:0] lineTable,
  input wire logic lineDone,
  input wire logic seqBusy,
  // Driver outputs
  input wire logic verticalOutA,
  input wire logic verticalOutB,
  input wire logic verticalOutF,
  input wire logic fastDumpGateOut,
  input wire logic thirdLevelStrobe,
  input wire logic verticalDriverEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence sTaken;
    lineStart && !seqBusy && lineTable < 4'h9;
  endsequence
  sequence sFlushTaken;
    lineStart && !seqBusy && lineTable == 4'h4;
  endsequence
  a_load_busy: assert property ($rose(arst_n) |-> ##1 seqBusy[*8])
    else $error("Busy dropped during the default load.");
  a_start_busy: assert property (sTaken |=> seqBusy)
    else $error("Accepted start did not raise busy.");
  a_done_pulse: assert property (lineDone |=> !lineDone)
    else $error("Done lasted more than one cycle.");
  a_done_idle: assert property (lineDone |-> !seqBusy)
    else $error("Done seen while still busy.");
  a_dump_copy: assert property (fastDumpGateOut == verticalOutF)
    else $error("Fast dump gate differs from output f.");
  a_strobe_copy: assert property (thirdLevelStrobe == verticalOutA)
    else $error("Strobe differs from output a.");
  a_enable_copy: assert property (verticalDriverEnable == verticalOutB)
    else $error("Driver enable differs from output b.");
  a_flush_dump: assert property (sFlushTaken |-> ##3 fastDumpGateOut[*8])
    else $error("Flush table did not hold the dump gate.");
  a_rdata_idle: assert property (!regRd |=> regRdata == 32'h0)
    else $error("Read data shown without a read.");
endmodule
bind cls_line_sequencer cls_line_sequencer_assertions u_cls_chk (
  .ref_clk, .arst_n, .regRd, .regRdata, .lineStart, .lineTable,
  .lineDone, .seqBusy, .verticalOutA, .verticalOutB, .verticalOutF,
  .fastDumpGateOut, .thirdLevelStrobe, .verticalDriverEnable);
`default_nettype wire

// ==== testbench/cls_ccd_driver_model.sv ====
// Behavioural model of the CCD vertical and horizontal clock drivers.
`timescale 1ns/100ps
`default_nettype none
module cls_ccd_driver_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Driver inputs
  input wire logic [5:0] vOut,
  input wire logic hGate,
  input wire logic clrStats,
  // Observations
  output logic [15:0] hShifts,
  output logic vAfterH
);
  // Once readout starts, phase c or d in the same line smears charge.
  logic hSeen;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hShifts <= 16'h0;
      hSeen <= 1'b0;
      vAfterH <= 1'b0;
    end else if (clrStats) begin
      hShifts <= 16'h0;
      hSeen <= 1'b0;
      vAfterH <= 1'b0;
    end else begin
      if (hGate) begin
        hShifts <= hShifts + 16'h1;
        hSeen <= 1'b1;
      end
      if (hSeen && (vOut[2] || vOut[3])) begin
        vAfterH <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the line-table sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic lineStart = 1'b0;
  logic [3:0] lineTable = 4'h0;
  logic verticalDriveTrigger = 1'b0;
  logic clrStats = 1'b0;
  wire [31:0] regRdata;
  wire lineDone, seqBusy, hGate, vAfterH;
  wire [5:0] vOut;
  wire [15:0] hShifts;
  int nFail = 0;
  int testsRun = 0;
  int ovC = 0;
  int ovD = 0;
  // Pattern bits are {f, e, d, c, b, a, gate}.
  logic [11:0] cntT [9][10] = '{
    '{1,1,30,1,30,1,0,0,0,0}, '{1,500,1,240,1,400,1310,0,0,0},
    '{1,0,0,0,0,0,0,0,0,0}, '{1,1,30,1,30,1,30,1,30,0},
    '{1,1,198,1,199,0,0,0,0,0}, '{1,0,0,0,0,0,0,0,0,0},
    '{1,25,1,25,0,0,0,0,0,0}, '{10,10,25,2,0,0,0,0,0,0},
    '{20,200,20,10,1,0,0,0,0,0}};
  logic [6:0] patT [9][10] = '{
    '{0,8,24,8,0,1,0,0,0,0}, '{0,8,10,26,10,8,0,0,0,0},
    '{1,0,0,0,0,0,0,0,0,0}, '{0,8,24,8,0,8,24,8,1,0},
    '{64,72,88,72,64,0,0,0,0,0}, '{0,0,0,0,0,0,0,0,0,0},
    '{0,8,10,26,0,0,0,0,0,0}, '{26,10,8,0,0,0,0,0,0,0},
    '{8,0,8,24,26,0,0,0,0,0}};

  cls_line_sequencer u_cls_line_sequencer (
    .ref_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .lineStart, .lineTable, .verticalDriveTrigger, .lineDone, .seqBusy,
    .verticalOutA(vOut[0]), .verticalOutB(vOut[1]), .verticalOutC(vOut[2]),
    .verticalOutD(vOut[3]), .verticalOutE(vOut[4]), .verticalOutF(vOut[5]),
    .fastDumpGateOut(), .thirdLevelStrobe(), .verticalDriverEnable(),
    .horizontalGate(hGate));
  cls_ccd_driver_model u_cls_ccd_driver_model (
    .ref_clk, .arst_n, .vOut, .hGate, .clrStats, .hShifts, .vAfterH);

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Reads and compares; read data is only valid in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    cmp(e, regRdata);
    @(posedge ref_clk);
  endtask
  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic regsTest;
    for (int t = 0; t < 9; t++) begin
      for (int e = 0; e < 10; e++) begin
        rd({t[3:0], e[3:0]}, {13'h0, patT[t][e], cntT[t][e]});
        if (cntT[t][e] == 0) break;
      end
    end
    rd(8'ha0, 32'h24);
    rd(8'ha4, 32'h0);
    wr(8'h9a, 32'h5);
    rd(8'h9a, 32'h0);
    $display("register defaults done");
  endtask
  // Runs one table and checks every pin cycle, with optional phase stretch.
  task automatic runTable(input int t);
    int cl, dl, h;
    logic [6:0] p, x;
    cl = 0;
    dl = 0;
    h = 0;
    clrStats <= 1'b1;
    lineStart <= 1'b1;
    lineTable <= t[3:0];
    @(posedge ref_clk);
    clrStats <= 1'b0;
    lineStart <= 1'b0;
    for (int e = 0; e < 10 && cntT[t][e] != 0; e++) begin
      for (int k = 0; k < cntT[t][e]; k++) begin
        p = patT[t][e];
        x = p;
        x[3] = p[3] | (cl > 0);
        x[4] = p[4] | (dl > 0);
        cl = p[3] ? ovC : (cl > 0 ? cl - 1 : 0);
        dl = p[4] ? ovD : (dl > 0 ? dl - 1 : 0);
        h += p[0];
        @(posedge ref_clk);
        @(negedge ref_clk);
        cmp({25'h0, x}, {25'h0, vOut, hGate});
      end
    end
    cmp(32'h1, {31'h0, lineDone});
    // The driver model counts the last gate cycle at the following edge.
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmp(h, {16'h0, hShifts});
    cmp(32'h0, {31'h0, vAfterH});
    @(posedge ref_clk);
    $display("table %0d done", t);
  endtask
  // Repeating table: refuses a start while busy, stops on the trigger.
  task automatic repeatTest(input int t);
    int k;
    lineStart <= 1'b1;
    lineTable <= t[3:0];
    @(posedge ref_clk);
    lineStart <= 1'b0;
    lineTable <= 4'h0;
    @(posedge ref_clk);
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      lineStart <= (k == 10);
      @(negedge ref_clk);
      cmp({24'h0, 1'b0, patT[t][0]}, {24'h0, lineDone, vOut, hGate});
    end
    @(posedge ref_clk);
    verticalDriveTrigger <= 1'b1;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (lineDone !== 1'b1 && k < 8);
    cmp(32'h1, {31'h0, lineDone});
    @(posedge ref_clk);
    verticalDriveTrigger <= 1'b0;
    @(negedge ref_clk);
    cmp(32'h0, {31'h0, seqBusy});
    @(posedge ref_clk);
    $display("repeat table %0d done", t);
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (seqBusy !== 1'b0 && k < 200);
    cmp(32'h0, {31'h0, seqBusy});
    regsTest;
    foreach (patT[t]) if (t != 2 && t != 5) runTable(t);
    repeatTest(2);
    repeatTest(5);
    wr(8'ha4, 32'h32);
    ovC = 2;
    ovD = 3;
    runTable(0);
    wr(8'ha4, 32'h0);
    ovC = 0;
    ovD = 0;
    wr(8'h60, {13'h0, 7'h64, 12'h3});
    patT[6][0] = 7'h64;
    cntT[6][0] = 12'h3;
    rd(8'h60, {13'h0, 7'h64, 12'h3});
    runTable(6);
    finishTest;
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    nFail++;
    $display("watchdog expired");
    finishTest;
  end
endmodule
`default_nettype wire
